/* File: common/bcub_consts.svh */
// bridge control field constants: offsets, bit positions, reset values
// assumes a 32-bit apb register map with byte addresses
`ifndef BCUB_CONSTS_SVH
`define BCUB_CONSTS_SVH

`define BCUB_OFF_CTRL      12'h03c
`define BCUB_OFF_IRQ_STAT  12'h100
`define BCUB_OFF_IRQ_MASK  12'h104
`define BCUB_OFF_LINE_STAT 12'h108

`define BCUB_BIT_PERR_EN   16
`define BCUB_BIT_SERR_FWD  17
`define BCUB_BIT_ISA_EN    18
`define BCUB_BIT_VGA_EN    19
`define BCUB_BIT_RSVD      20
`define BCUB_BIT_MA_MODE   21
`define BCUB_BIT_SEC_RST   22
`define BCUB_BIT_FB2B_EN   23

`define BCUB_CTRL_RESET    8'h00
`define BCUB_CTRL_WMASK    8'hef

`define BCUB_IO_ISA_LIMIT  32'h0001_0000
`define BCUB_ALL_ONES      32'hffff_ffff

`define BCUB_EV_PERR       0
`define BCUB_EV_SERR       1
`define BCUB_EV_MABORT     2
`define BCUB_EV_ISA_BLOCK  3
`define BCUB_NUM_EVENTS    4

`endif

/* File: common/bcub_pkg.sv */
// types for the bridge control block
// assumes nothing beyond a systemverilog compiler
package bcub_pkg;
  typedef enum logic [1:0] {
    BCUB_MA_SILENT = 2'b00,
    BCUB_MA_REPORT = 2'b01
  } bcub_ma_t;

  typedef enum logic [1:0] {
    BCUB_IO_NONE = 2'b00,
    BCUB_IO_DOWN = 2'b01,
    BCUB_IO_UP   = 2'b11
  } bcub_io_route_t;
endpackage

/* File: verilog/bcub_io_filter.sv */
// isa alias and vga address decode for i/o and memory cycles
// assumes addresses presented alongside a valid strobe from the bridge core
`timescale 1ns/1ps
`include "bcub_consts.svh"
module bcub_io_filter (
  input  wire logic [31:0]      addr,
  input  wire logic             is_io,
  input  wire logic             in_io_window,
  input  wire logic             isa_en,
  input  wire logic             vga_en,
  output bcub_pkg::bcub_io_route_t route_down,
  output logic                  isa_upstream,
  output logic                  isa_blocked
);
  logic isa_alias;
  logic vga_hit;

  // last 768 bytes of each 1kb block: bits 9:8 nonzero
  assign isa_alias = (addr[9:8] != 2'b00);
  assign isa_blocked = isa_en && is_io && in_io_window && isa_alias &&
                       (addr < `BCUB_IO_ISA_LIMIT);

  always_comb begin
    vga_hit = 1'b0;
    if (is_io) begin
      vga_hit = (addr[15:0] >= 16'h03b0 && addr[15:0] <= 16'h03bb) ||
                (addr[15:0] >= 16'h03c0 && addr[15:0] <= 16'h03df);
    end else begin
      vga_hit = (addr >= 32'h000a_0000) && (addr <= 32'h000b_ffff);
    end
  end

  always_comb begin
    route_down = bcub_pkg::BCUB_IO_NONE;
    if (vga_en && vga_hit) begin
      route_down = bcub_pkg::BCUB_IO_DOWN;
    end else if (is_io && in_io_window && !isa_blocked) begin
      route_down = bcub_pkg::BCUB_IO_DOWN;
    end
  end // vga hits without vga_en fall through

  assign isa_upstream = isa_en && is_io && isa_alias;
endmodule

/* File: verilog/bcub_ctrl.sv */
// bridge control field (config dword 3ch bits 23:16) with apb access
// assumes synchronous status inputs from the bridge core on pclk
// How it works
// - with the parity enable bit clear, secondary parity errors are ignored.
// - with the parity enable bit set, secondary parity errors are detected and reported.
// - the system error forward bit gates secondary system error onto the primary side.
// - with the isa bit clear, every in-window i/o address is forwarded.
// - with the isa bit set, in-window aliases below 64kb in the top 768 bytes of 1kb stay put, except vga addresses while the vga bit is set.
// - with the isa bit set, secondary i/o in the top 768 bytes of 1kb goes upstream.
// - with the vga bit clear, vga addresses are passed downstream only as in-window i/o.
// - with the vga bit set, vga addresses pass downstream regardless of other settings.
// - bit 20 is reserved, reads zero and resets to zero.
// - with master abort mode clear, aborts are silent, reads give all ones, writes drop.
// - with master abort mode set, aborts signal target abort and primary system error if enabled.
// - with the reset bit set, the secondary reset output is held asserted.
// - with the reset bit clear, only other sources drive the secondary reset.
// - the fast back-to-back bit governs fast back-to-back to different secondary devices.
// - fast back-to-back is off at reset and while the bit is zero.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "bcub_consts.svh"
module bcub_ctrl #(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  input  wire logic              sec_parity_err,
  input  wire logic              secondary_system_error_n,
  input  wire logic              primary_serr_en,
  output logic                   primary_system_error_n,
  output logic                   sec_parity_report,
  input  wire logic              other_sec_reset_n,
  output logic                   sec_reset_n,
  input  wire logic              sec_master_abort,
  input  wire logic              abort_is_read,
  output logic                   signal_target_abort,
  output logic                   return_all_ones,
  output logic                   discard_write,
  output logic      [31:0]       abort_read_data,
  input  wire logic [31:0]       req_addr,
  input  wire logic              req_is_io,
  input  wire logic              req_in_io_window,
  input  wire logic              req_from_secondary,
  output logic                   forward_down,
  output logic                   forward_up,
  output logic                   fast_b2b_allowed
);
  initial begin
    if (ADDR_W < 12) begin
      $error("bcub_ctrl: ADDR_W must be at least 12");
    end
  end

  localparam int NEV = `BCUB_NUM_EVENTS;

  logic [7:0]     ctrl_q;
  logic [NEV-1:0] stat_q;
  logic [NEV-1:0] mask_q;
  logic [NEV-1:0] ev;
  logic           wr_acc;
  logic           hit_ctrl;
  logic           hit_stat;
  logic           hit_mask;
  logic           hit_line;
  logic           map_hit;
  logic           serr_fwd;
  logic           ma_report;
  bcub_pkg::bcub_io_route_t route;
  logic           isa_up;
  logic           isa_blk;

  assign hit_ctrl = (paddr[11:0] == `BCUB_OFF_CTRL);
  assign hit_stat = (paddr[11:0] == `BCUB_OFF_IRQ_STAT);
  assign hit_mask = (paddr[11:0] == `BCUB_OFF_IRQ_MASK);
  assign hit_line = (paddr[11:0] == `BCUB_OFF_LINE_STAT);
  assign map_hit  = hit_ctrl | hit_stat | hit_mask | hit_line;
  assign wr_acc   = psel && penable && pwrite && map_hit;

  // zero wait state slave
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !map_hit;

  // control field lives in byte lane 2; reserved bit masked off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `BCUB_CTRL_RESET;
    end else if (wr_acc && hit_ctrl && pstrb[2]) begin
      ctrl_q <= pwdata[23:16] & `BCUB_CTRL_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= '0;
    end else if (wr_acc && hit_mask && pstrb[0]) begin
      mask_q <= pwdata[NEV-1:0];
    end
  end

  // sticky events: set wins over write-one-to-clear
  genvar gi;
  generate
    for (gi = 0; gi < NEV; gi++) begin : g_stat
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stat_q[gi] <= 1'b0;
        end else if (ev[gi]) begin
          stat_q[gi] <= 1'b1;
        end else if (wr_acc && hit_stat && pstrb[0] && pwdata[gi]) begin
          stat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(stat_q & mask_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (hit_ctrl) begin
        prdata[23:16] <= ctrl_q;
      end else if (hit_stat) begin
        prdata[NEV-1:0] <= stat_q;
      end else if (hit_mask) begin
        prdata[NEV-1:0] <= mask_q;
      end else if (hit_line) begin
        prdata[3:0] <= {fast_b2b_allowed, ~sec_reset_n, ~primary_system_error_n,
                        sec_parity_report};
      end
    end
  end

  // parity handling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_parity_report <= 1'b0;
    end else begin
      sec_parity_report <= sec_parity_err && ctrl_q[`BCUB_BIT_PERR_EN - 16];
    end
  end

  // system error forwarding and master abort reporting
  assign ma_report = ctrl_q[`BCUB_BIT_MA_MODE - 16];
  assign serr_fwd  = ctrl_q[`BCUB_BIT_SERR_FWD - 16] && !secondary_system_error_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_system_error_n <= 1'b1;
    end else begin
      primary_system_error_n <= !(primary_serr_en &&
                                  (serr_fwd || (sec_master_abort && ma_report)));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      signal_target_abort <= 1'b0;
      return_all_ones     <= 1'b0;
      discard_write       <= 1'b0;
      abort_read_data     <= 32'h0000_0000;
    end else begin
      signal_target_abort <= sec_master_abort && ma_report;
      return_all_ones     <= sec_master_abort && !ma_report && abort_is_read;
      discard_write       <= sec_master_abort && !ma_report && !abort_is_read;
      abort_read_data     <= (sec_master_abort && !ma_report && abort_is_read) ?
                             `BCUB_ALL_ONES : 32'h0000_0000;
    end
  end

  // secondary reset: forced by bit 22, otherwise follows other sources
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_reset_n <= 1'b0;
    end else begin
      sec_reset_n <= other_sec_reset_n && !ctrl_q[`BCUB_BIT_SEC_RST - 16];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_b2b_allowed <= 1'b0;
    end else begin
      fast_b2b_allowed <= ctrl_q[`BCUB_BIT_FB2B_EN - 16];
    end
  end

  bcub_io_filter u_filter (
    .addr         (req_addr),
    .is_io        (req_is_io),
    .in_io_window (req_in_io_window),
    .isa_en       (ctrl_q[`BCUB_BIT_ISA_EN - 16]),
    .vga_en       (ctrl_q[`BCUB_BIT_VGA_EN - 16]),
    .route_down   (route),
    .isa_upstream (isa_up),
    .isa_blocked  (isa_blk)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      forward_down <= 1'b0;
      forward_up   <= 1'b0;
    end else begin
      forward_down <= !req_from_secondary && (route == bcub_pkg::BCUB_IO_DOWN);
      forward_up   <= req_from_secondary && isa_up;
    end
  end

  always_comb begin
    ev = '0;
    ev[`BCUB_EV_PERR]      = sec_parity_err && ctrl_q[`BCUB_BIT_PERR_EN - 16];
    ev[`BCUB_EV_SERR]      = serr_fwd;
    ev[`BCUB_EV_MABORT]    = sec_master_abort && ma_report;
    ev[`BCUB_EV_ISA_BLOCK] = isa_blk && !req_from_secondary;
  end
endmodule

/* File: verif/bcub_core_model.sv */
// core side model: drives the status and transaction inputs of bcub_ctrl
// assumes one pclk domain; each event lasts one cycle
`timescale 1ns/1ps
module bcub_core_model (
  input  wire logic        pclk,
  output logic             sec_parity_err,
  output logic             secondary_system_error_n,
  output logic             primary_serr_en,
  output logic             other_sec_reset_n,
  output logic             sec_master_abort,
  output logic             abort_is_read,
  output logic      [31:0] req_addr,
  output logic             req_is_io,
  output logic             req_in_io_window,
  output logic             req_from_secondary
);
  initial begin
    {sec_parity_err, sec_master_abort, primary_serr_en, abort_is_read} = '0;
    {secondary_system_error_n, other_sec_reset_n} = 2'b11;
    {req_addr, req_is_io, req_in_io_window, req_from_secondary} = '0;
  end
  // t: {io, in window, from secondary, read}; e: {parity, abort, serr enable, serr}
  task automatic drive(input logic [31:0] a, input logic [3:0] t, input logic [3:0] e);
    @(posedge pclk);
    {req_addr, req_is_io, req_in_io_window, req_from_secondary, abort_is_read} <= {a, t};
    {sec_parity_err, sec_master_abort, primary_serr_en, secondary_system_error_n} <= e ^ 4'h1;
    @(posedge pclk);
    {sec_parity_err, sec_master_abort, secondary_system_error_n} <= 3'b001;
  endtask
endmodule

/* File: verif/bcub_ctrl_chk.sv */
// assertions on the ports of bcub_ctrl
// assumes pready tied high and a shadow of the control byte
`timescale 1ns/1ps
`include "bcub_consts.svh"
module bcub_ctrl_chk #(
  parameter int ADDR_W = 12
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              sec_parity_err,
  input wire logic              sec_parity_report,
  input wire logic              sec_reset_n,
  input wire logic              fast_b2b_allowed,
  input wire logic              sec_master_abort,
  input wire logic              signal_target_abort,
  input wire logic [31:0]       req_addr,
  input wire logic              req_is_io,
  input wire logic              req_in_io_window,
  input wire logic              req_from_secondary,
  input wire logic              forward_down
);
  logic [7:0] c_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) c_q <= 8'h00;
    else if (psel && penable && pwrite && paddr == `BCUB_OFF_CTRL && pstrb[2])
      c_q <= pwdata[23:16] & 8'hef;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_perr_on; sec_parity_err && c_q[0] |=> sec_parity_report; endproperty
  a_perr_on: assert property (p_perr_on) else $error("parity not reported");
  property p_perr_off; !c_q[0] |=> !sec_parity_report; endproperty
  a_perr_off: assert property (p_perr_off) else $error("parity reported");
  property p_srst; c_q[6] |=> !sec_reset_n; endproperty
  a_srst: assert property (p_srst) else $error("secondary reset not held");
  property p_fb2b; fast_b2b_allowed == $past(c_q[7]); endproperty
  a_fb2b: assert property (p_fb2b) else $error("fast b2b mismatch");
  property p_rsvd; psel && penable && !pwrite && paddr == `BCUB_OFF_CTRL
    |-> prdata[23:16] == c_q; endproperty
  a_rsvd: assert property (p_rsvd) else $error("control readback wrong");
  property p_ma_rep; sec_master_abort && c_q[5] |=> signal_target_abort; endproperty
  a_ma_rep: assert property (p_ma_rep) else $error("abort not reported");
  property p_ma_quiet; sec_master_abort && !c_q[5] |=> !signal_target_abort; endproperty
  a_ma_quiet: assert property (p_ma_quiet) else $error("abort reported");
  property p_isa; req_is_io && req_in_io_window && !req_from_secondary && c_q[2] && !c_q[3]
    && req_addr[31:16] == 16'h0000 && req_addr[9:8] != 2'b00 |=> !forward_down; endproperty
  a_isa: assert property (p_isa) else $error("isa alias forwarded");
  property p_vga; c_q[3] && !req_from_secondary && !req_is_io
    && req_addr[31:17] == 15'h0005 |=> forward_down; endproperty
  a_vga: assert property (p_vga) else $error("vga memory not forwarded");
  c_perr: cover property (sec_parity_err && c_q[0]);
  c_srst: cover property (c_q[6]);
  c_abort: cover property (sec_master_abort && c_q[5]);
endmodule
bind bcub_ctrl bcub_ctrl_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

/* File: verif/testbench.sv */
// bench for the bridge control block: apb driver, scenarios, verdict
// assumes bcub_ctrl at the top and the core model beside it
`timescale 1ns/1ps
`include "bcub_consts.svh"
`define CHK(a, b) begin #1; total_checks++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t mismatch", $time); end end
module testbench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, abort_read_data, req_addr, rd;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, irq, sec_parity_err, secondary_system_error_n, se,
    primary_serr_en, primary_system_error_n, sec_parity_report, other_sec_reset_n,
    sec_reset_n, sec_master_abort, abort_is_read, signal_target_abort, return_all_ones,
    discard_write, req_is_io, req_in_io_window, req_from_secondary, forward_down,
    forward_up, fast_b2b_allowed;
  int          errors = 0, total_checks = 0;
  always #2.5 pclk = ~pclk;
  bcub_ctrl u_bcub_ctrl (.*);
  bcub_core_model core (.*);
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {rd, se} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic t_regs;
    apb(1'b0, `BCUB_OFF_CTRL, '0);
    `CHK(rd, 32'h0000_0000)
    `CHK(pready, 1'b1)
    apb(1'b1, `BCUB_OFF_CTRL, 32'hffff_ffff);
    apb(1'b0, `BCUB_OFF_CTRL, '0);
    `CHK(rd, 32'h00ef_0000)
    apb(1'b0, 12'h200, '0);
    `CHK(se, 1'b1)
    apb(1'b1, `BCUB_OFF_CTRL, '0);
  endtask
  task automatic t_parity;
    core.drive(32'h0, 4'h0, 4'h8);
    `CHK(sec_parity_report, 1'b0)
    apb(1'b1, `BCUB_OFF_CTRL, 32'h0001_0000);
    core.drive(32'h0, 4'h0, 4'h8);
    `CHK(sec_parity_report, 1'b1)
    `CHK(irq, 1'b0)
    apb(1'b1, `BCUB_OFF_IRQ_MASK, 32'h1);
    `CHK(irq, 1'b1)
    apb(1'b1, `BCUB_OFF_IRQ_STAT, 32'h1);
    `CHK(irq, 1'b0)
    apb(1'b1, `BCUB_OFF_IRQ_MASK, 32'h0);
  endtask
  task automatic t_abort;
    core.drive(32'h0, 4'h1, 4'h4);
    `CHK({return_all_ones, signal_target_abort, abort_read_data}, {2'b10, 32'hffff_ffff})
    core.drive(32'h0, 4'h0, 4'h4);
    `CHK(discard_write, 1'b1)
    apb(1'b1, `BCUB_OFF_CTRL, 32'h0020_0000);
    core.drive(32'h0, 4'h0, 4'h6);
    `CHK({signal_target_abort, primary_system_error_n}, 2'b10)
  endtask
  task automatic t_rst;
    apb(1'b1, `BCUB_OFF_CTRL, 32'h00c2_0000);
    @(posedge pclk);
    `CHK({sec_reset_n, fast_b2b_allowed}, 2'b01)
    core.drive(32'h0, 4'h0, 4'h3);
    `CHK(primary_system_error_n, 1'b0)
    apb(1'b1, `BCUB_OFF_CTRL, '0);
    core.drive(32'h0, 4'h0, 4'h3);
    `CHK({sec_reset_n, fast_b2b_allowed, primary_system_error_n}, 3'b101)
  endtask
  task automatic t_fwd;
    core.drive(32'h0000_0500, 4'hc, 4'h2);
    `CHK(forward_down, 1'b1)
    apb(1'b1, `BCUB_OFF_CTRL, 32'h0004_0000);
    core.drive(32'h0000_0500, 4'hc, 4'h2);
    `CHK(forward_down, 1'b0)
    core.drive(32'h0000_0500, 4'he, 4'h2);
    `CHK(forward_up, 1'b1)
    core.drive(32'h000a_0000, 4'h0, 4'h2);
    `CHK(forward_down, 1'b0)
    apb(1'b1, `BCUB_OFF_CTRL, 32'h000c_0000);
    core.drive(32'h000a_0000, 4'h0, 4'h2);
    `CHK(forward_down, 1'b1)
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_parity;
    t_abort;
    t_rst;
    t_fwd;
    results;
  end
  initial begin
    #20000;
    errors++;
    results;
  end
endmodule
